/* File: hdl/mfcr_top.v */
// Purpose: modem mode configuration registers and decoded mode outputs
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: datapath and line logic consume the decoded outputs
//
// Added by the designer: the Avalon-MM slave port.
`include "mfcr_regs.vh"

module mfcr_top #(
    parameter DIALTO_UNIT_CYC = `MFCR_DIALTO_UNIT_CYC
) (
    input wire mclk,
    input wire resetn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [1:0] avs_response,
    input wire tone_dial_cmd,
    input wire dial_tone_seen,
    input wire tone_on_evt,
    input wire tone_off_evt,
    input wire echo_mode_active,
    input wire ninth_bit_in,
    output reg dial_start_ff,
    output reg [2:0] tx_rate_ff,
    output reg [2:0] rx_rate_ff,
    output reg frame_mode_enable_ff,
    output reg tone_detect_enable_ff,
    output reg fsk300_enable_ff,
    output reg intl_vs_us_standard_select_ff,
    output reg seizure_pattern_monitor_ff,
    output reg alert_ff,
    output reg frame_end_marker_ff,
    output reg band_swap_loopback_ff,
    output reg echo_valid_ff,
    output reg [7:0] echo_char_ff,
    output reg [2:0] onhook_threshold_ff,
    output reg [4:0] onhook_abs_level_ff,
    output reg onhook_use_diff_ff,
    output reg [2:0] offhook_threshold_ff,
    output reg [4:0] offhook_abs_level_ff,
    output reg offhook_use_diff_ff,
    output reg wetting_pulse_enable_ff,
    output reg current_limit_offhook_ff,
    output reg japan_callerid_ff,
    output reg uk_callerid_ff,
    output reg us_callerid_ff,
    output reg pcm_mode_ff
);

// ----------------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------------
reg [7:0] mode1_ff;
reg [7:0] mode2_ff;
reg [7:0] onhook_ff;
reg [7:0] offhook_ff;
reg [7:0] mode3_ff;
reg [7:0] link_ff;
reg [7:0] dialto_ff;
reg pend_ff;

wire [5:0] idx = avs_address[7:2];
wire word_ok = (avs_address[1:0] == 2'b00);
wire acc = (avs_read | avs_write) & avs_waitrequest & pend_ff;
wire wr = acc & avs_write & avs_byteenable[0] & word_ok;
wire tmr_busy;
wire tmr_expire;
reg [7:0] nxt_rdata;
reg hit;

// ----------------------------------------------------------------------
// Bus slave: one cycle of wait, answer on second edge
// ----------------------------------------------------------------------
always @* begin
    nxt_rdata = 8'h00;
    hit = word_ok;
    case (idx)
        `MFCR_IDX_MODE1: nxt_rdata = mode1_ff;
        `MFCR_IDX_MODE2: nxt_rdata = mode2_ff & `MFCR_MODE2_MASK;
        `MFCR_IDX_ONHOOK: nxt_rdata = onhook_ff;
        `MFCR_IDX_OFFHOOK: nxt_rdata = offhook_ff;
        `MFCR_IDX_MODE3: nxt_rdata = mode3_ff;
        `MFCR_IDX_LINK: nxt_rdata = link_ff;
        `MFCR_IDX_DIALTO: nxt_rdata = dialto_ff;
        `MFCR_IDX_STATUS: nxt_rdata = {6'h00, dial_start_ff, tmr_busy};
        `MFCR_IDX_TONES: nxt_rdata = {2'h0, tx_rate_ff, rx_rate_ff};
        default: hit = 1'b0;
    endcase
end

always @(posedge mclk) begin
    if (!resetn) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h0;
        avs_response <= 2'b00;
        pend_ff <= 1'b0;
    end else begin
        avs_waitrequest <= 1'b1;
        pend_ff <= 1'b0;
        if ((avs_read | avs_write) & avs_waitrequest & !pend_ff) begin
            pend_ff <= 1'b1;
        end
        if (acc) begin
            // Release with answer; unmapped gives zero and decode error
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h0, nxt_rdata};
            avs_response <= hit ? 2'b00 : 2'b11;
        end
    end
end

// ----------------------------------------------------------------------
// Register writes (low byte lane only)
// ----------------------------------------------------------------------
always @(posedge mclk) begin
    if (!resetn) begin
        mode1_ff <= `MFCR_RST_MODE1;
        mode2_ff <= `MFCR_RST_MODE2;
        onhook_ff <= `MFCR_RST_ONHOOK;
        offhook_ff <= `MFCR_RST_OFFHOOK;
        mode3_ff <= `MFCR_RST_MODE3;
        link_ff <= `MFCR_RST_LINK;
        dialto_ff <= `MFCR_RST_DIALTO;
    end else if (wr) begin
        case (idx)
            `MFCR_IDX_MODE1: mode1_ff <= avs_writedata[7:0];
            `MFCR_IDX_MODE2: mode2_ff <= avs_writedata[7:0]
                & `MFCR_MODE2_MASK;
            `MFCR_IDX_ONHOOK: onhook_ff <= avs_writedata[7:0];
            `MFCR_IDX_OFFHOOK: offhook_ff <= avs_writedata[7:0];
            `MFCR_IDX_MODE3: mode3_ff <= avs_writedata[7:0];
            `MFCR_IDX_LINK: link_ff <= avs_writedata[7:0];
            `MFCR_IDX_DIALTO: dialto_ff <= avs_writedata[7:0];
            default: mode1_ff <= mode1_ff;
        endcase
    end
end

// ----------------------------------------------------------------------
// Rate decode
// ----------------------------------------------------------------------
wire rev_rx = mode1_ff[`MFCR_M1_REVRX];
wire fwd_tx = mode1_ff[`MFCR_M1_FWDTX];
wire rsel = mode1_ff[`MFCR_M1_RATE];
reg [2:0] nxt_tx;
reg [2:0] nxt_rx;

always @* begin
    nxt_tx = rsel ? `MFCR_RATE_2400 : `MFCR_RATE_1200;
    nxt_rx = nxt_tx;
    if (rev_rx & fwd_tx) begin
        nxt_tx = rsel ? `MFCR_RATE_1200 : `MFCR_RATE_600;
        nxt_rx = nxt_tx;
    end else if (rev_rx) begin
        nxt_tx = `MFCR_RATE_75;
        nxt_rx = rsel ? `MFCR_RATE_1200 : `MFCR_RATE_600;
    end else if (fwd_tx) begin
        nxt_tx = rsel ? `MFCR_RATE_1200 : `MFCR_RATE_600;
        nxt_rx = `MFCR_RATE_75;
    end
    if (mode1_ff[`MFCR_M1_FSK]) begin
        // FSK overrides the negotiated carrier rates
        nxt_tx = `MFCR_RATE_300;
        nxt_rx = `MFCR_RATE_300;
    end
end

// ----------------------------------------------------------------------
// Dialing: immediate or after dial-tone wait
// ----------------------------------------------------------------------
wire delayed = mode2_ff[`MFCR_M2_DBLIND];

mfcr_dial_timer #(
    .UNIT_CYC(DIALTO_UNIT_CYC)
) u_dial_timer (
    .mclk(mclk),
    .resetn(resetn),
    .start(tone_dial_cmd & delayed & !mode1_ff[`MFCR_M1_BLIND]),
    .abort(dial_tone_seen),
    .units(dialto_ff),
    .busy_ff(tmr_busy),
    .expire_ff(tmr_expire)
);

always @(posedge mclk) begin
    if (!resetn) begin
        dial_start_ff <= 1'b0;
    end else begin
        dial_start_ff <= (tone_dial_cmd & mode1_ff[`MFCR_M1_BLIND])
            | tmr_expire
            | (tmr_busy & dial_tone_seen);
    end
end

// ----------------------------------------------------------------------
// Decoded mode outputs
// ----------------------------------------------------------------------
wire ninth_esc = link_ff[`MFCR_LK_ESC];

always @(posedge mclk) begin
    if (!resetn) begin
        tx_rate_ff <= `MFCR_RATE_1200;
        rx_rate_ff <= `MFCR_RATE_1200;
        frame_mode_enable_ff <= 1'b0;
        tone_detect_enable_ff <= 1'b0;
        fsk300_enable_ff <= 1'b0;
        intl_vs_us_standard_select_ff <= 1'b0;
        seizure_pattern_monitor_ff <= 1'b0;
        alert_ff <= 1'b0;
        frame_end_marker_ff <= 1'b0;
        band_swap_loopback_ff <= 1'b0;
        echo_valid_ff <= 1'b0;
        echo_char_ff <= 8'h00;
        onhook_threshold_ff <= 3'h0;
        onhook_abs_level_ff <= 5'h00;
        onhook_use_diff_ff <= 1'b0;
        offhook_threshold_ff <= 3'h0;
        offhook_abs_level_ff <= 5'h00;
        offhook_use_diff_ff <= 1'b0;
        wetting_pulse_enable_ff <= 1'b0;
        current_limit_offhook_ff <= 1'b0;
        japan_callerid_ff <= 1'b0;
        uk_callerid_ff <= 1'b0;
        us_callerid_ff <= 1'b0;
        pcm_mode_ff <= 1'b0;
    end else begin
        tx_rate_ff <= nxt_tx;
        rx_rate_ff <= nxt_rx;
        frame_mode_enable_ff <= mode1_ff[`MFCR_M1_FRAME];
        tone_detect_enable_ff <= mode1_ff[`MFCR_M1_TONEDET];
        fsk300_enable_ff <= mode1_ff[`MFCR_M1_FSK];
        intl_vs_us_standard_select_ff <= mode1_ff[`MFCR_M1_INTL];
        seizure_pattern_monitor_ff <= mode2_ff[`MFCR_M2_SEIZE];
        // Ninth bit routed only with escape enabled
        alert_ff <= ninth_esc & ninth_bit_in
            & !mode2_ff[`MFCR_M2_NINTH];
        frame_end_marker_ff <= ninth_esc & ninth_bit_in
            & mode2_ff[`MFCR_M2_NINTH];
        band_swap_loopback_ff <= mode2_ff[`MFCR_M2_LOOP];
        echo_valid_ff <= mode2_ff[`MFCR_M2_ECHO] & echo_mode_active
            & (tone_on_evt | tone_off_evt);
        if (tone_on_evt) begin
            echo_char_ff <= `MFCR_ECHO_PERIOD;
        end else if (tone_off_evt) begin
            echo_char_ff <= `MFCR_ECHO_SLASH;
        end
        onhook_threshold_ff <= onhook_ff[7:5];
        onhook_abs_level_ff <= onhook_ff[4:0];
        offhook_threshold_ff <= offhook_ff[7:5];
        offhook_abs_level_ff <= offhook_ff[4:0];
        onhook_use_diff_ff <= mode3_ff[`MFCR_M3_ONM];
        offhook_use_diff_ff <= mode3_ff[`MFCR_M3_OFFM];
        wetting_pulse_enable_ff <= !mode3_ff[`MFCR_M3_WETN];
        current_limit_offhook_ff <= mode3_ff[`MFCR_M3_CLIM];
        japan_callerid_ff <= mode3_ff[`MFCR_M3_JAPAN];
        uk_callerid_ff <= mode3_ff[`MFCR_M3_UK];
        us_callerid_ff <= mode3_ff[`MFCR_M3_US];
        // Host must set fast serial rate and flow control first
        pcm_mode_ff <= mode3_ff[`MFCR_M3_PCM];
    end
end

endmodule // mfcr_top

/* File: include/mfcr_regs.vh */
// Purpose: register map and field layout of the modem mode configuration
// Assumes: Avalon-MM slave, 32-bit data, one word per register
// Notes: printed offsets are register indices; byte address = 4 * index
//
// What this block does
// - Immediate blind-dial bit starts tone dialing without waiting for dial tone.
// - Reverse-rate bit: send 75 bps, receive 600 or 1200 by rate select.
// - Forward-rate bit: send 600 or 1200 by rate select, receive 75.
// - No V.23 bits: 1200/2400 baud; both V.23 bits: 600/1200.
// - Seizure pattern monitor bit searches continuously; off after reset.
// - Ninth-bit meaning applies only with escape: 0 alert, 1 end-of-frame.
// - Delayed blind-dial bit dials as soon as dial tone is seen during the wait, or once the dial-tone wait timeout expires.
// - Loopback bit swaps transmit and receive frequency bands.
// - Tone-echo bit echoes period for tone on, slash for tone off.
// - On-hook register bits 7:5 hold the differential voltage threshold.
// - On-hook register bits 4:0 hold the absolute voltage threshold.
// - Off-hook register bits 7:5 hold the differential current threshold.
// - Off-hook register bits 4:0 hold the absolute current threshold.
// - Wetting-pulse bit is active low: 0 enables, 1 disables the pulse.
// - Current-limit off-hook bit enables off hook for overcurrent protection.
// - Off-hook method bit: 0 absolute, 1 differential current threshold.
// - On-hook method bit: 0 absolute, 1 differential voltage threshold.
// - UK caller ID decode enabled when its bit is 1.
// - North American caller ID decode enabled when its bit is 1.
// - Link control bit 0 enables the ninth-bit escape function.
`ifndef MFCR_REGS_VH
`define MFCR_REGS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define MFCR_IDX_MODE1 6'h07
`define MFCR_IDX_MODE2 6'h0c
`define MFCR_IDX_ONHOOK 6'h11
`define MFCR_IDX_OFFHOOK 6'h12
`define MFCR_IDX_MODE3 6'h13
`define MFCR_IDX_LINK 6'h15
`define MFCR_IDX_DIALTO 6'h02
`define MFCR_IDX_STATUS 6'h20
`define MFCR_IDX_TONES 6'h21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MFCR_RST_MODE1 8'h00
`define MFCR_RST_MODE2 8'h00
`define MFCR_RST_ONHOOK 8'h4d
`define MFCR_RST_OFFHOOK 8'h00
`define MFCR_RST_MODE3 8'h00
`define MFCR_RST_LINK 8'h00
`define MFCR_RST_DIALTO 8'h04
`define MFCR_MODE2_MASK 8'h2f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MFCR_M1_FRAME 7
`define MFCR_M1_BLIND 6
`define MFCR_M1_REVRX 5
`define MFCR_M1_FWDTX 4
`define MFCR_M1_TONEDET 3
`define MFCR_M1_RATE 2
`define MFCR_M1_INTL 1
`define MFCR_M1_FSK 0
`define MFCR_M2_SEIZE 5
`define MFCR_M2_NINTH 3
`define MFCR_M2_DBLIND 2
`define MFCR_M2_LOOP 1
`define MFCR_M2_ECHO 0
`define MFCR_M3_JAPAN 7
`define MFCR_M3_WETN 6
`define MFCR_M3_CLIM 5
`define MFCR_M3_OFFM 4
`define MFCR_M3_ONM 3
`define MFCR_M3_UK 2
`define MFCR_M3_US 1
`define MFCR_M3_PCM 0
`define MFCR_LK_ESC 0

// ----------------------------------------------------------------------
// Rate codes and timing
// ----------------------------------------------------------------------
`define MFCR_RATE_75 3'h0
`define MFCR_RATE_300 3'h1
`define MFCR_RATE_600 3'h2
`define MFCR_RATE_1200 3'h3
`define MFCR_RATE_2400 3'h4
`define MFCR_CLK_HZ 10000000
`define MFCR_DIALTO_UNIT_MS 1000
`define MFCR_DIALTO_UNIT_CYC (`MFCR_CLK_HZ / 1000 * `MFCR_DIALTO_UNIT_MS)
`define MFCR_ECHO_PERIOD 8'h2e
`define MFCR_ECHO_SLASH 8'h2f

`endif

/* File: hdl/mfcr_dial_timer.v */
// Purpose: dial-tone wait timer for delayed blind dialing
// Assumes: one tick per unit, count loaded on start
// Notes: expiry is a one-cycle pulse; no restart while counting
`include "mfcr_regs.vh"

module mfcr_dial_timer #(
    parameter UNIT_CYC = `MFCR_DIALTO_UNIT_CYC
) (
    input wire mclk,
    input wire resetn,
    input wire start,
    input wire abort,
    input wire [7:0] units,
    output reg busy_ff,
    output reg expire_ff
);

reg [31:0] tick_ff;
reg [7:0] left_ff;

always @(posedge mclk) begin
    if (!resetn) begin
        tick_ff <= 32'h0;
        left_ff <= 8'h00;
        busy_ff <= 1'b0;
        expire_ff <= 1'b0;
    end else begin
        expire_ff <= 1'b0;
        if (abort) begin
            busy_ff <= 1'b0;
        end else if (!busy_ff) begin
            if (start) begin
                busy_ff <= 1'b1;
                left_ff <= units;
                tick_ff <= 32'h0;
            end
        end else if (left_ff == 8'h00) begin
            // Timeout reached: dial without dial tone
            busy_ff <= 1'b0;
            expire_ff <= 1'b1;
        end else if (tick_ff == UNIT_CYC - 1) begin
            tick_ff <= 32'h0;
            left_ff <= left_ff - 8'h01;
        end else begin
            tick_ff <= tick_ff + 32'h1;
        end
    end
end

endmodule // mfcr_dial_timer

/* File: tb/mfcr_props.sv */
// Purpose: port checker for the mode configuration registers
// Assumes: one wait state per access, field copies one edge later
// Notes: shadows the blind-dial bit from the writes it observes
module mfcr_props (
    input wire mclk,
    input wire resetn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire avs_waitrequest,
    input wire [1:0] avs_response,
    input wire tone_dial_cmd,
    input wire tone_on_evt,
    input wire echo_mode_active,
    input wire ninth_bit_in,
    input wire dial_start_ff,
    input wire frame_mode_enable_ff,
    input wire seizure_pattern_monitor_ff,
    input wire alert_ff,
    input wire frame_end_marker_ff,
    input wire band_swap_loopback_ff,
    input wire echo_valid_ff,
    input wire [7:0] echo_char_ff,
    input wire [2:0] onhook_threshold_ff,
    input wire [4:0] onhook_abs_level_ff,
    input wire [2:0] offhook_threshold_ff,
    input wire [4:0] offhook_abs_level_ff,
    input wire offhook_use_diff_ff,
    input wire wetting_pulse_enable_ff,
    input wire uk_callerid_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // Shadow
    // --------
    wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    reg [7:0] d_ff;
    reg blind_ff;
    always @(posedge mclk) begin
        d_ff <= avs_writedata[7:0];
        if (!resetn)
            blind_ff <= 1'b0;
        else if (acc && avs_address == 8'h1c)
            blind_ff <= avs_writedata[6];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_WAIT_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("access not answered");
    AST_REFUSE: assert property ((avs_read || avs_write) && !avs_waitrequest
        && avs_address[1:0] != 2'h0 |-> avs_response == 2'h3)
        else $error("misaligned access not refused");
    AST_M1: assert property (
        acc && avs_address == 8'h1c |=> frame_mode_enable_ff == d_ff[7])
        else $error("frame mode copy wrong");
    AST_M2: assert property (
        acc && avs_address == 8'h30 |=> seizure_pattern_monitor_ff == d_ff[5]
        && band_swap_loopback_ff == d_ff[1]) else $error("mode two copy wrong");
    AST_ONHOOK: assert property (
        acc && avs_address == 8'h44 |=> onhook_threshold_ff == d_ff[7:5]
        && onhook_abs_level_ff == d_ff[4:0]) else $error("on-hook copy wrong");
    AST_OFFHOOK: assert property (
        acc && avs_address == 8'h48 |=> offhook_threshold_ff == d_ff[7:5]
        && offhook_abs_level_ff == d_ff[4:0]) else $error("off-hook copy wrong");
    AST_M3: assert property (
        acc && avs_address == 8'h4c |=> wetting_pulse_enable_ff == !d_ff[6]
        && offhook_use_diff_ff == d_ff[4] && uk_callerid_ff == d_ff[2])
        else $error("mode three copy wrong");
    AST_ECHO: assert property (
        echo_valid_ff |-> $past(echo_mode_active)
        && echo_char_ff == ($past(tone_on_evt) ? 8'h2e : 8'h2f))
        else $error("echo character wrong");
    AST_NINTH: assert property (
        alert_ff || frame_end_marker_ff |-> $past(ninth_bit_in)
        && !(alert_ff && frame_end_marker_ff)) else $error("ninth bit wrong");
    AST_BLIND: assert property (
        tone_dial_cmd && blind_ff |=> dial_start_ff) else $error("no dial");
    AST_PULSE: assert property (dial_start_ff |=> !dial_start_ff)
        else $error("dial start not a pulse");
endmodule // mfcr_props

/* File: tb/mfcr_host.sv */
// Purpose: host bus master for the mode registers
// Assumes: slave answers by dropping waitrequest
// Notes: released address and write data go inverted so stale values never look valid; read, write drop to 0
module mfcr_host (
    input wire mclk,
    output reg [7:0] avs_address = 8'h00,
    output reg avs_read = 1'b0,
    output reg avs_write = 1'b0,
    output reg [31:0] avs_writedata = 32'h0,
    output reg [3:0] avs_byteenable = 4'h0,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [1:0] avs_response
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // Access
    // --------
    task acc(input [7:0] a, input w, input [31:0] d, input [3:0] be,
        output [31:0] q, output [1:0] r);
        begin
            avs_address <= a;
            avs_read <= !w;
            avs_write <= w;
            avs_writedata <= d;
            avs_byteenable <= be;
            @(posedge mclk);
            while (avs_waitrequest !== 1'b0) @(posedge mclk);
            q = avs_readdata;
            r = avs_response;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            avs_address <= ~a;
            avs_writedata <= ~d;
        end
    endtask
endmodule // mfcr_host

/* File: tb/modem_function_config_regs_bench.sv */
// Purpose: self-checking bench for the mode configuration registers
// Assumes: dial timer unit shortened to 10 cycles
// Notes: expected outputs come from an array model of the registers
module modem_function_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // Bench
    // --------
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg tone_dial_cmd = 1'b0;
    reg dial_tone_seen = 1'b0;
    reg tone_on_evt = 1'b0;
    reg tone_off_evt = 1'b0;
    reg echo_mode_active = 1'b0;
    reg ninth_bit_in = 1'b0;
    wire [7:0] avs_address, echo_char_ff;
    wire avs_read, avs_write, avs_waitrequest;
    wire [31:0] avs_writedata, avs_readdata;
    wire [3:0] avs_byteenable;
    wire [1:0] avs_response;
    wire [2:0] tx_rate_ff, rx_rate_ff, onhook_threshold_ff;
    wire [2:0] offhook_threshold_ff;
    wire [4:0] onhook_abs_level_ff, offhook_abs_level_ff;
    wire dial_start_ff, frame_mode_enable_ff, tone_detect_enable_ff;
    wire fsk300_enable_ff, intl_vs_us_standard_select_ff;
    wire seizure_pattern_monitor_ff, alert_ff, frame_end_marker_ff;
    wire band_swap_loopback_ff, echo_valid_ff, onhook_use_diff_ff;
    wire offhook_use_diff_ff, wetting_pulse_enable_ff;
    wire current_limit_offhook_ff, japan_callerid_ff, uk_callerid_ff;
    wire us_callerid_ff, pcm_mode_ff;
    wire [35:0] outs = {tx_rate_ff, rx_rate_ff, frame_mode_enable_ff,
        tone_detect_enable_ff, fsk300_enable_ff,
        intl_vs_us_standard_select_ff, seizure_pattern_monitor_ff,
        band_swap_loopback_ff, onhook_threshold_ff, onhook_abs_level_ff,
        onhook_use_diff_ff, offhook_threshold_ff, offhook_abs_level_ff,
        offhook_use_diff_ff, wetting_pulse_enable_ff,
        current_limit_offhook_ff, japan_callerid_ff, uk_callerid_ff,
        us_callerid_ff, pcm_mode_ff};
    integer failures = 0;
    integer n_tests = 0;
    integer i, n;
    reg [31:0] lfsr = 32'hfffa2f3d;
    reg [31:0] x;
    reg [7:0] a, v;
    reg [7:0] m [0:63];
    reg [5:0] idxs [0:6] = '{6'h02, 6'h07, 6'h0c, 6'h11, 6'h12, 6'h13, 6'h15};

    mfcr_top #(.DIALTO_UNIT_CYC(10)) dut_u (.*);
    mfcr_host host_u (.*);

    initial forever #50 mclk = ~mclk;

    function [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        rnd = lfsr;
    endfunction
    function ok(input [7:0] p);
        ok = p[1:0] == 2'h0 && p[7:2] inside {6'h02, 6'h07, 6'h0c, 6'h11,
            6'h12, 6'h13, 6'h15};
    endfunction
    function [5:0] rates(input [7:0] p);
        reg [2:0] h;
        begin
            h = {2'b01, p[2]};
            if (p[0]) rates = 6'h09;
            else if (p[5] && !p[4]) rates = {3'h0, h};
            else if (p[4] && !p[5]) rates = {h, 3'h0};
            else if (p[4]) rates = {h, h};
            else rates = {h + 3'h1, h + 3'h1};
        end
    endfunction
    function [35:0] eo();
        reg [7:0] p, b, t;
        begin
            p = m[7];
            b = m[12];
            t = m[19];
            eo = {rates(p), p[7], p[3], p[0], p[1], b[5], b[1], m[17], t[3],
                m[18], t[4], !t[6], t[5], t[7], t[2], t[1], t[0]};
        end
    endfunction
    task chk_bus(input string nm, input [33:0] e, input [33:0] g);
        begin
            n_tests++;
            if (g !== e) begin
                failures++;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chk_out(input string nm, input [35:0] e, input [35:0] g);
        begin
            n_tests++;
            if (g !== e) begin
                failures++;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] p, input [7:0] d, input [3:0] be);
        reg [31:0] q;
        reg [1:0] r;
        begin
            @(posedge mclk);
            q = rnd();
            host_u.acc(p, 1'b1, {q[31:8], d}, be, q, r);
            if (ok(p) && be[0]) m[p[7:2]] = d & (p == 8'h30 ? 8'h2f : 8'hff);
            chk_bus("wresp", {ok(p) ? 2'h0 : 2'h3, 32'h0}, {r, 32'h0});
        end
    endtask
    task rd(input [7:0] p);
        reg [31:0] q;
        reg [1:0] r;
        begin
            @(posedge mclk);
            host_u.acc(p, 1'b0, rnd(), 4'hf, q, r);
            // Misaligned reads still return the word's register
            chk_bus("read", {ok(p) ? 2'h0 : 2'h3, 24'h0,
                ok({p[7:2], 2'b00}) ? m[p[7:2]] : 8'h00}, {r, q});
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        for (i = 0; i < 64; i++) m[i] = 8'h00;
        m[17] = 8'h4d;
        m[2] = 8'h04;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) rd({idxs[i], 2'b00});
        @(negedge mclk);
        chk_out("reset", eo(), outs);
        for (i = 0; i < 256; i++) begin
            wr(8'h1c, i[7:0], 4'hf);
            @(negedge mclk);
            chk_out("mode1", eo(), outs);
        end
        for (i = 0; i < 60; i++) begin
            x = rnd();
            n = 1 + x[15:8] % 5;
            a = x[3:2] == 2'b11 ? x[23:16] & 8'h7f : {idxs[n], 2'b00};
            v = x[31:24];
            // PCM stays off: the serial rate lives outside this block
            if (a == 8'h4c) v[0] = 1'b0;
            wr(a, v, x[3:2] == 2'b10 ? 4'he : 4'hf);
            rd(a);
            @(negedge mclk);
            chk_out("modes", eo(), outs);
            chk_out("methods", eo(), outs);
        end
        for (i = 0; i < 8; i++) begin
            wr(8'h54, {7'h0, i[0]}, 4'hf);
            wr(8'h30, {4'h0, i[1], 3'h0}, 4'hf);
            ninth_bit_in <= i[2];
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            x = {30'h0, i[0] & i[2] & !i[1], i[0] & i[2] & i[1]};
            chk_out("ninth", x,
                {alert_ff, frame_end_marker_ff});
        end
        echo_mode_active <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(8'h30, {7'h0, i[0]}, 4'hf);
            tone_on_evt <= i[1];
            tone_off_evt <= !i[1];
            @(posedge mclk);
            tone_on_evt <= 1'b0;
            tone_off_evt <= 1'b0;
            @(negedge mclk);
            x = i[0] ? (i[1] ? 32'h12e : 32'h12f) : 32'h0;
            chk_out("echo", x, {echo_valid_ff,
                echo_valid_ff ? echo_char_ff : 8'h00});
        end
        wr(8'h08, 8'h02, 4'hf);
        for (i = 0; i < 3; i++) begin
            wr(8'h1c, i ? 8'h00 : 8'h40, 4'hf);
            wr(8'h30, i ? 8'h04 : 8'h00, 4'hf);
            tone_dial_cmd <= 1'b1;
            @(posedge mclk);
            tone_dial_cmd <= 1'b0;
            // Last pass: dial tone arrives while the timer waits
            dial_tone_seen <= i == 2;
            n = 0;
            @(negedge mclk);
            while (dial_start_ff !== 1'b1 && n < 100) begin
                @(negedge mclk);
                n++;
            end
            x = i == 2 ? (n == 1) : (i ? (n >= 19 && n <= 26) : (n == 0));
            chk_out("dial", 36'h1, x);
        end
        give_verdict;
    end

    initial begin
        #1_000_000;
        failures++;
        give_verdict;
    end
endmodule // modem_function_config_regs_bench

bind mfcr_top mfcr_props p_u (.*);
